// ===== pin_sync3.sv
// Three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/1ns
module pin_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,    // Main clock
    input  wire logic rst,    // Async reset, active high
    input  wire logic pin,    // Asynchronous pin level
    output logic      level   // Filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // Level changes only once stages two and three agree
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg    <= RST_VAL;
            s2_reg    <= RST_VAL;
            s3_reg    <= RST_VAL;
            level_reg <= RST_VAL;
        end else begin
            s1_reg    <= pin;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule

// ===== reset_boot_defs.svh
// Constants for the reset, strap and boot-order control block
// Functional notes
// - Power-on reset input is active low
// - Watchdog reset drives the shutdown output picked by shut_sel_b low
// - Overtemperature trip goes to reset unit
// - Overtemperature trip may drive shutdown low
// - Boot media tried in fixed priority
// - No firmware found enters USB recovery
// - Straps sampled after reset set defaults
// - Voltage strap low 3.3V, high 1.8V
// - IO voltage mode fixed from strap only
// - Card-detect high debug, low SD card
// - Both straps default high by pull-up
// - Debug entry only with card-detect high
// - SWD uses clock input and data line
`ifndef RESET_BOOT_DEFS_SVH
`define RESET_BOOT_DEFS_SVH

// Main clock and reset qualification time
// Rates in kHz so the product below stays inside 32-bit integers
`define MAIN_CLK_KHZ       250000
`define REF_CLK_KHZ        24000
`define POR_MIN_REF_CYC    100
// Least width rounds up: ceil(100 * 250 MHz / 24 MHz)
`define POR_MIN_CYC \
    ((`POR_MIN_REF_CYC * `MAIN_CLK_KHZ + `REF_CLK_KHZ - 1) / `REF_CLK_KHZ)
`define POR_CNT_W          11
// Width of the watchdog / trip shutdown pulse in clocks
`define SHUT_PULSE_CYC     16
`define SHUT_CNT_W         5
// Boot source count
`define BOOT_SRC_NUM       5
`define BOOT_IDX_W         3

`endif

// ===== reset_boot_pkg.sv
// Types shared by the reset, strap and boot-order control block
package reset_boot_pkg;

    // Boot sources in descending priority
    typedef enum logic [2:0] {
        BOOT_NOR,
        BOOT_SNAND,
        BOOT_PNAND,
        BOOT_EMMC,
        BOOT_SDCARD,
        BOOT_RECOVERY
    } boot_src_t;

    // Strap-derived power-on configuration
    typedef struct packed {
        logic io_1v8;       // 1 = 1.8 V flash IO mode, 0 = 3.3 V
        logic pins_debug;   // 1 = debug/serial, 0 = SD card
    } strap_cfg_t;

    // Boot progress seen by the outside
    typedef struct packed {
        boot_src_t src;
        logic      busy;
        logic      done;
        logic      recovery;
    } boot_stat_t;

endpackage

// ===== reset_boot_strap_control.sv
// Reset qualification, shutdown drive, strap capture and boot ordering
`timescale 1ns/1ns
`include "reset_boot_defs.svh"
module reset_boot_strap_control (
    input  wire logic       clk,               // Main clock, 250 MHz
    input  wire logic       rst,               // Async reset, active high
    input  wire logic       power_on_reset_n,  // Reset pin, active low
    input  wire logic       boot_io_voltage_strap, // Flash IO strap pin
    input  wire logic       card_detect_strap, // Card-detect strap pin
    input  wire logic       wdt_reset,         // Watchdog reset request
    input  wire logic       overtemp_trip_a,   // Trip from converter A
    input  wire logic       overtemp_trip_b,   // Trip from converter B
    input  wire logic       trip_ext_en,       // Trip also drives pins
    input  wire logic       shut_sel_b,        // Use output b, not a
    input  wire logic       media_ready,       // Probed medium answered
    input  wire logic       media_has_fw,      // Probed medium has image
    input  wire logic       debug_req,         // Debug entry requested
    input  wire logic       swd_clk_pin,       // SWD clock pin
    input  wire logic       swd_data_in,       // SWD data pin level
    input  wire logic       swd_data_oe_core,  // Debug core drives data
    input  wire logic       swd_data_out_core, // Debug core data
    output logic            chip_reset,        // Internal reset, active high
    output logic            clock_reset_unit_req, // Trip reset to unit
    output logic            thermal_shutdown_out_a, // Shutdown pin a
    output logic            thermal_shutdown_out_b, // Shutdown pin b
    output reset_boot_pkg::strap_cfg_t strap_cfg, // Latched straps
    output reset_boot_pkg::boot_stat_t boot_stat, // Boot progress
    output logic            probe_start,       // Pulse: probe boot_stat.src
    output logic            usb_otg_port0_recovery, // Recovery device on
    output logic            debug_enable,      // Debug port usable
    output logic            swd_clk,           // Synchronised SWD clock
    output logic            swd_data_core_in,  // Synchronised SWD data
    output logic            swd_data_out,      // SWD data pin drive
    output logic            swd_data_oe        // SWD data pin enable
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic por_n_s;
    logic vstrap_s;
    logic cdet_s;
    logic swdc_s;
    logic swdd_s;

    // Reset pin idles high once the power chip releases it
    pin_sync3 #(.RST_VAL(1'b0)) u_por (
        .clk   (clk),
        .rst   (rst),
        .pin   (power_on_reset_n),
        .level (por_n_s)
    );
    // Straps reset to the pull-up level
    pin_sync3 #(.RST_VAL(1'b1)) u_vstrap (
        .clk   (clk),
        .rst   (rst),
        .pin   (boot_io_voltage_strap),
        .level (vstrap_s)
    );
    pin_sync3 #(.RST_VAL(1'b1)) u_cdet (
        .clk   (clk),
        .rst   (rst),
        .pin   (card_detect_strap),
        .level (cdet_s)
    );
    pin_sync3 #(.RST_VAL(1'b0)) u_swdc (
        .clk   (clk),
        .rst   (rst),
        .pin   (swd_clk_pin),
        .level (swdc_s)
    );
    pin_sync3 #(.RST_VAL(1'b0)) u_swdd (
        .clk   (clk),
        .rst   (rst),
        .pin   (swd_data_in),
        .level (swdd_s)
    );

    // ----------------------------------------------------------------
    // Reset qualification
    // ----------------------------------------------------------------
    localparam logic [`POR_CNT_W-1:0] POR_MIN =
        `POR_CNT_W'(`POR_MIN_CYC);
    logic [`POR_CNT_W-1:0] low_cnt_reg;
    logic [`POR_CNT_W-1:0] low_cnt_next;
    logic                  in_reset_reg;
    logic                  in_reset_next;
    logic                  latch_reg;
    logic                  latch_next;

    // Low holds reset; a glitch shorter than the minimum is ignored
    // so spikes on the pin cannot restart the chip
    always_comb begin
        low_cnt_next  = low_cnt_reg;
        in_reset_next = in_reset_reg;
        latch_next    = 1'b0;
        if (!por_n_s) begin
            if (low_cnt_reg != POR_MIN) begin
                low_cnt_next = low_cnt_reg + `POR_CNT_W'(1);
            end else begin
                in_reset_next = 1'b1;
            end
        end else begin
            low_cnt_next = '0;
            if (in_reset_reg) begin
                in_reset_next = 1'b0;
                latch_next    = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_reg  <= '0;
            in_reset_reg <= 1'b1;
            latch_reg    <= 1'b0;
        end else begin
            low_cnt_reg  <= low_cnt_next;
            in_reset_reg <= in_reset_next;
            latch_reg    <= latch_next;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    reset_boot_pkg::strap_cfg_t cfg_reg;
    reset_boot_pkg::strap_cfg_t cfg_next;

    // Only reset release loads straps; nothing else writes them
    always_comb begin
        cfg_next = cfg_reg;
        if (latch_reg) begin
            cfg_next.io_1v8     = vstrap_s;
            cfg_next.pins_debug = cdet_s;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= '{io_1v8: 1'b1, pins_debug: 1'b1};
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ----------------------------------------------------------------
    // Shutdown outputs and trip routing
    // ----------------------------------------------------------------
    logic [`SHUT_CNT_W-1:0] shut_cnt_reg;
    logic [`SHUT_CNT_W-1:0] shut_cnt_next;
    logic                   shut_a_reg;
    logic                   shut_b_reg;
    logic                   shut_a_next;
    logic                   shut_b_next;
    logic                   cru_reg;
    logic                   cru_next;
    logic                   trip;
    logic                   fire;

    assign trip = overtemp_trip_a | overtemp_trip_b;
    assign fire = wdt_reset | (trip & trip_ext_en);

    // Pulse is stretched so an external reset IC sees it reliably
    always_comb begin
        shut_cnt_next = shut_cnt_reg;
        cru_next      = trip;
        if (fire) begin
            shut_cnt_next = `SHUT_CNT_W'(`SHUT_PULSE_CYC);
        end else if (shut_cnt_reg != '0) begin
            shut_cnt_next = shut_cnt_reg - `SHUT_CNT_W'(1);
        end
        shut_a_next = !((shut_cnt_next != '0) && !shut_sel_b);
        shut_b_next = !((shut_cnt_next != '0) && shut_sel_b);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shut_cnt_reg <= '0;
            shut_a_reg   <= 1'b1;
            shut_b_reg   <= 1'b1;
            cru_reg      <= 1'b0;
        end else begin
            shut_cnt_reg <= shut_cnt_next;
            shut_a_reg   <= shut_a_next;
            shut_b_reg   <= shut_b_next;
            cru_reg      <= cru_next;
        end
    end

    // ----------------------------------------------------------------
    // Boot sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_PROBE,
        ST_WAIT,
        ST_END
    } boot_st_t;

    boot_st_t                  st_reg;
    boot_st_t                  st_next;
    reset_boot_pkg::boot_src_t src_reg;
    reset_boot_pkg::boot_src_t src_next;
    logic                      start_reg;
    logic                      start_next;

    // Walks sources high to low priority; recovery if none has an image
    always_comb begin
        st_next    = st_reg;
        src_next   = src_reg;
        start_next = 1'b0;
        case (st_reg)
            ST_HOLD: begin
                src_next = reset_boot_pkg::BOOT_NOR;
                if (latch_reg) begin
                    st_next = ST_PROBE;
                end
            end
            ST_PROBE: begin
                start_next = 1'b1;
                st_next    = ST_WAIT;
            end
            ST_WAIT: begin
                if (media_ready) begin
                    if (media_has_fw) begin
                        st_next = ST_END;
                    end else if (src_reg == reset_boot_pkg::BOOT_SDCARD) begin
                        src_next = reset_boot_pkg::BOOT_RECOVERY;
                        st_next  = ST_END;
                    end else begin
                        src_next = reset_boot_pkg::boot_src_t'(
                            src_reg + 3'h1);
                        st_next  = ST_PROBE;
                    end
                end
            end
            ST_END: begin
                st_next = ST_END;
            end
            default: begin
                st_next = ST_HOLD;
            end
        endcase
        if (in_reset_next) begin
            st_next = ST_HOLD;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg    <= ST_HOLD;
            src_reg   <= reset_boot_pkg::BOOT_NOR;
            start_reg <= 1'b0;
        end else begin
            st_reg    <= st_next;
            src_reg   <= src_next;
            start_reg <= start_next;
        end
    end

    // ----------------------------------------------------------------
    // Debug port gating
    // ----------------------------------------------------------------
    logic dbg_reg;
    logic dbg_next;
    logic swdc_reg;
    logic swdd_reg;
    logic swdo_reg;
    logic swdoe_reg;
    logic swdo_next;
    logic swdoe_next;

    // Debug closed when the card-detect strap was sampled low
    always_comb begin
        dbg_next   = debug_req & cfg_next.pins_debug;
        swdoe_next = dbg_next & swd_data_oe_core;
        swdo_next  = swdoe_next & swd_data_out_core;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dbg_reg   <= 1'b0;
            swdc_reg  <= 1'b0;
            swdd_reg  <= 1'b0;
            swdo_reg  <= 1'b0;
            swdoe_reg <= 1'b0;
        end else begin
            dbg_reg   <= dbg_next;
            swdc_reg  <= swdc_s;
            swdd_reg  <= swdd_s;
            swdo_reg  <= swdo_next;
            swdoe_reg <= swdoe_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs from flip-flops; boot_stat flags and USB recovery decoded from st_reg and src_reg
    // ----------------------------------------------------------------
    assign chip_reset             = in_reset_reg;
    assign clock_reset_unit_req   = cru_reg;
    assign thermal_shutdown_out_a = shut_a_reg;
    assign thermal_shutdown_out_b = shut_b_reg;
    assign strap_cfg              = cfg_reg;
    assign boot_stat.src          = src_reg;
    assign boot_stat.busy         = (st_reg == ST_PROBE) | (st_reg == ST_WAIT);
    assign boot_stat.done         = (st_reg == ST_END);
    assign boot_stat.recovery     = (src_reg == reset_boot_pkg::BOOT_RECOVERY);
    assign probe_start            = start_reg;
    assign usb_otg_port0_recovery = boot_stat.recovery;
    assign debug_enable           = dbg_reg;
    assign swd_clk                = swdc_reg;
    assign swd_data_core_in       = swdd_reg;
    assign swd_data_out           = swdo_reg;
    assign swd_data_oe            = swdoe_reg;
endmodule

// ===== reset_boot_strap_control_monitor.sv
// Checker bound to the reset, strap and boot-order block
`timescale 1ns/1ns
module reset_boot_strap_control_monitor (
    input wire logic clk,                    // Clock
    input wire logic rst,                    // Reset
    input wire logic power_on_reset_n,       // Reset pin
    input wire logic boot_io_voltage_strap,  // Strap
    input wire logic card_detect_strap,      // Strap
    input wire logic wdt_reset,              // Watchdog
    input wire logic overtemp_trip_a,        // Trip
    input wire logic overtemp_trip_b,        // Trip
    input wire logic trip_ext_en,            // Trip to pin
    input wire logic shut_sel_b,             // Pin select
    input wire logic media_ready,            // Answer
    input wire logic media_has_fw,           // Image
    input wire logic swd_data_oe_core,       // Core drive
    input wire logic chip_reset,             // Reset out
    input wire logic clock_reset_unit_req,   // Trip out
    input wire logic thermal_shutdown_out_a, // Pin a
    input wire logic thermal_shutdown_out_b, // Pin b
    input wire reset_boot_pkg::strap_cfg_t strap_cfg, // Straps
    input wire reset_boot_pkg::boot_stat_t boot_stat, // Boot
    input wire logic probe_start,            // Probe
    input wire logic usb_otg_port0_recovery, // Recovery
    input wire logic debug_enable,           // Debug
    input wire logic swd_data_oe             // SWD enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wait_reg;
    logic miss;
    // Answer window opens the cycle after probe_start; the block also takes an answer in the probe_start cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            wait_reg <= 1'b0;
        else if (probe_start)
            wait_reg <= 1'b1;
        else if (media_ready)
            wait_reg <= 1'b0;
    end
    assign miss = wait_reg && media_ready && !media_has_fw;
    wdt_pin_a: assert property (
        wdt_reset && !shut_sel_b |=> !thermal_shutdown_out_a)
        else $error("watchdog left pin a high");
    trip_fwd_a: assert property (
        clock_reset_unit_req == $past(overtemp_trip_a || overtemp_trip_b))
        else $error("trip not forwarded");
    trip_pin_a: assert property (
        (overtemp_trip_a || overtemp_trip_b) && trip_ext_en && shut_sel_b
        |=> !thermal_shutdown_out_b) else $error("trip left pin b high");
    shut_hold_a: assert property (
        $fell(thermal_shutdown_out_a) |-> (!thermal_shutdown_out_a) [*8]
        ##1 (!thermal_shutdown_out_a) [*8]) else $error("short shutdown");
    strap_latch_a: assert property (
        $fell(chip_reset) |=> strap_cfg ==
        {boot_io_voltage_strap, card_detect_strap})
        else $error("straps not latched");
    mode_fixed_a: assert property (
        !chip_reset && !$past(chip_reset) && !$past(chip_reset, 2)
        |-> $stable(strap_cfg)) else $error("strap mode changed");
    boot_order_a: assert property (@(posedge clk)
        disable iff (rst || chip_reset)
        $changed(boot_stat.src) && !$past(chip_reset)
        |-> boot_stat.src == $past(boot_stat.src) + 3'h1)
        else $error("boot source out of order");
    probe_next_a: assert property (
        miss && boot_stat.src != reset_boot_pkg::BOOT_SDCARD
        |-> ##2 probe_start) else $error("next probe late");
    recov_usb_a: assert property (
        miss && boot_stat.src == reset_boot_pkg::BOOT_SDCARD
        |=> usb_otg_port0_recovery && boot_stat.recovery)
        else $error("recovery not entered");
    debug_gate_a: assert property (
        debug_enable |-> strap_cfg.pins_debug)
        else $error("debug open with card strap low");
    swd_oe_a: assert property (
        swd_data_oe == (debug_enable && $past(swd_data_oe_core)))
        else $error("swd enable not following core");
    por_rel_a: assert property (
        $fell(chip_reset) |-> $past(power_on_reset_n, 2))
        else $error("reset released with pin low");
    rec_c: cover property (usb_otg_port0_recovery);
    fw_c: cover property (boot_stat.done && !boot_stat.recovery);
    shut_c: cover property ($fell(thermal_shutdown_out_b));
endmodule

bind reset_boot_strap_control reset_boot_strap_control_monitor mon_i (
    .clk(clk), .rst(rst), .power_on_reset_n(power_on_reset_n),
    .boot_io_voltage_strap(boot_io_voltage_strap),
    .card_detect_strap(card_detect_strap), .wdt_reset(wdt_reset),
    .overtemp_trip_a(overtemp_trip_a), .overtemp_trip_b(overtemp_trip_b),
    .trip_ext_en(trip_ext_en), .shut_sel_b(shut_sel_b),
    .media_ready(media_ready), .media_has_fw(media_has_fw),
    .swd_data_oe_core(swd_data_oe_core), .chip_reset(chip_reset),
    .clock_reset_unit_req(clock_reset_unit_req),
    .thermal_shutdown_out_a(thermal_shutdown_out_a),
    .thermal_shutdown_out_b(thermal_shutdown_out_b),
    .strap_cfg(strap_cfg), .boot_stat(boot_stat),
    .probe_start(probe_start), .debug_enable(debug_enable),
    .usb_otg_port0_recovery(usb_otg_port0_recovery),
    .swd_data_oe(swd_data_oe));

// ===== reset_boot_strap_control_tb.sv
// Self-checking bench for the reset, strap and boot-order block
`timescale 1ns/1ns
`include "reset_boot_defs.svh"
module reset_boot_strap_control_tb;
    logic        clk, rst, por_n, io_s, cd_s, wdt, tr_a, tr_b, ext, sel;
    logic        rdy, fw, dreq, sck, sdi, oec, outc, go, crst, clock_reset_unit;
    logic        sh_a, sh_b, probe, usb, den, s_ck, s_di, s_o, s_oe;
    logic [15:0] len;
    int          n_mismatch = 0;
    int          tests_run = 0;
    reset_boot_pkg::strap_cfg_t cfg;
    reset_boot_pkg::boot_stat_t st;

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    reset_boot_strap_control reset_boot_strap_control_i (
        .clk(clk), .rst(rst), .power_on_reset_n(por_n),
        .boot_io_voltage_strap(io_s), .card_detect_strap(cd_s),
        .wdt_reset(wdt), .overtemp_trip_a(tr_a), .overtemp_trip_b(tr_b),
        .trip_ext_en(ext), .shut_sel_b(sel), .media_ready(rdy),
        .media_has_fw(fw), .debug_req(dreq), .swd_clk_pin(sck),
        .swd_data_in(sdi), .swd_data_oe_core(oec),
        .swd_data_out_core(outc), .chip_reset(crst),
        .clock_reset_unit_req(clock_reset_unit), .thermal_shutdown_out_a(sh_a),
        .thermal_shutdown_out_b(sh_b), .strap_cfg(cfg), .boot_stat(st),
        .probe_start(probe), .usb_otg_port0_recovery(usb),
        .debug_enable(den), .swd_clk(s_ck), .swd_data_core_in(s_di),
        .swd_data_out(s_o), .swd_data_oe(s_oe));
    reset_source_model reset_source_model_i (
        .clk(clk), .start(go), .low_cyc(len), .power_on_reset_n(por_n));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Wait for reset release, then straps must be latched
    task automatic settle(input logic io, input logic cd);
        int w;
        w = 0;
        while (crst !== 1'b0 && w < 3000) begin
            cyc(1);
            w++;
        end
        chk(crst, 1'b0);
        cyc(1);
        chk(cfg, {io, cd});
    endtask

    // Straps are set before the pin goes low and held through it
    task automatic pin_rst(input logic io, input logic cd, input int n);
        io_s = io;
        cd_s = cd;
        len = 16'(n);
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(n + 2);
        chk(crst, n >= `POR_MIN_CYC);
    endtask

    // Reference walk of the boot order; image sits at fw_at, 5 = none
    task automatic boot(input int fw_at);
        int k;
        int w;
        for (k = 0; k < 5; k++) begin
            w = 0;
            while (probe !== 1'b1 && w < 40) begin
                cyc(1);
                w++;
            end
            chk({probe, st.busy, st.src}, {2'h3, 3'(k)});
            cyc(1);
            rdy = 1'b1;
            fw = (k == fw_at);
            cyc(1);
            rdy = 1'b0;
            if (k == fw_at)
                break;
        end
        cyc(2);
        chk({st.done, st.busy, st.recovery, usb},
            {2'h2, {2{fw_at > 4}}});
        chk(st.src, 8'(fw_at > 4 ? 5 : fw_at));
    endtask

    // Main sequence
    initial begin
        int j;
        int i;
        int w;
        logic [3:0] r;
        logic [3:0] ex;
        logic [1:0] pv;
        void'($urandom(32'h063450B1));
        rst = 1'b1;
        pv = 2'h3;
        {io_s, cd_s} = 2'h3;
        {wdt, tr_a, tr_b, ext, sel, rdy, fw, dreq} = 8'h00;
        {sck, sdi, oec, outc, go} = 5'h00;
        len = 16'h0000;
        cyc(16);
        rst = 1'b0;
        settle(1'b1, 1'b1);
        boot(5);
        for (j = 0; j < 4; j++) begin
            pin_rst(j[1], j[0], 1000);
            chk(cfg, pv);
            pin_rst(j[1], j[0], 1100);
            settle(j[1], j[0]);
            pv = j[1:0];
            boot($urandom % 5);
            r = 4'($urandom);
            {sck, sdi, oec, outc} = r;
            dreq = 1'b1;
            cyc(2);
            chk(den, j[0]);
            cyc(3);
            // Data line is driven only while the debug port is open
            ex = {r[3:2], r[1] & j[0], r[1] & r[0] & j[0]};
            chk({s_ck, s_di, s_oe, s_o}, ex);
            dreq = 1'b0;
        end
        // Watchdog, trip with pin drive, trip without; both pins
        for (i = 0; i < 6; i++) begin
            sel = i[0];
            ext = (i < 4);
            wdt = (i < 2);
            tr_a = (i / 2 == 1);
            tr_b = (i > 3);
            cyc(1);
            chk(clock_reset_unit, i > 1);
            {wdt, tr_a, tr_b} = 3'h0;
            w = 0;
            while ((sel ? sh_b : sh_a) === 1'b0 && w < 30) begin
                cyc(1);
                w++;
            end
            chk(8'(w), 8'(i < 4 ? 16 : 0));
            chk(sel ? sh_a : sh_b, 1'b1);
            cyc(2);
        end
        finish_test();
    end

    // Hang guard: the run needs about 11000 clocks
    initial begin
        cyc(30000);
        n_mismatch++;
        finish_test();
    end
endmodule

// ===== reset_source_model.sv
// Behavioural reset source that drives the block's reset pin
`timescale 1ns/1ns
module reset_source_model (
    input  wire logic        clk,              // Main clock
    input  wire logic        start,            // Pull line low again
    input  wire logic [15:0] low_cyc,          // Low time in clocks
    output logic             power_on_reset_n  // Reset line
);
    int cnt = 2000;  // Supplies ramp at power-up, line held low
    // Reload on request, count down after each edge
    always @(posedge clk) begin
        if (start)
            cnt <= low_cyc;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    // Released only once the supplies are counted down
    assign power_on_reset_n = (cnt == 0);
endmodule
